// [core/sub_bridge_config.sv]
// Configuration register set and safe-monitor actions of the bridge
`timescale 1ns/1ps
module sub_bridge_config #(parameter int unsigned MS_CYCLES = sub_pkg::MS_CYCLES)
(
   // System
   input  wire logic       clock,
   input  wire logic       sys_rst,
   // SPI link
   input  wire logic       spi_sclk,
   input  wire logic       spi_cs_n,
   input  wire logic       spi_mosi,
   output logic            spi_miso,
   output logic            spi_miso_oe,
   // Operating state and chain events, same clock
   input  wire logic       safe_monitor_mode,
   input  wire logic       sleep_mode,
   input  wire logic       chain_error,
   input  wire logic       poll_result,
   input  wire logic       comm_fault,
   // Configuration outputs
   output logic [7:0]      chain_count_q,
   output logic [7:0]      baud_code_q,
   output logic [1:0]      master_single_select_q,
   output logic            single_uart_master_q,
   output logic [3:0]      comm_retry_count_q,
   output logic [3:0]      comm_timeout_delay_q,
   output logic            sleep_alert_packet_enable_q,
   output logic            sleep_balance_notify_q,
   // Actions
   output logic            error_flag_q,
   output logic            safe_poll_q,
   output logic            sleep_poll_q,
   output logic            host_irq_q,
   output logic            contactor_open_q,
   output logic            mcu_reset_q,
   output logic            comm_handover_q,
   output logic [3:0]      gpio_out_q
);
   logic [7:0]  cfg_q [sub_pkg::REG_NUM];
   logic [7:0]  spi_cmd;
   logic [7:0]  spi_data;
   logic        spi_tgl;
   logic        tgl_s;
   logic        tgl_prev_q;
   logic [7:0]  rd_data;

   sub_spi_link u_link
   (
      .spi_sclk    (spi_sclk),
      .spi_cs_n    (spi_cs_n),
      .spi_mosi    (spi_mosi),
      .spi_miso    (spi_miso),
      .spi_miso_oe (spi_miso_oe),
      .sys_rst     (sys_rst),
      .rd_data     (rd_data),
      .cmd_q       (spi_cmd),
      .data_q      (spi_data),
      .done_tgl_q  (spi_tgl)
   );

   sub_sync #(.W(1)) u_sync
   (
      .clock    (clock),
      .sys_rst  (sys_rst),
      .async_in (spi_tgl),
      .sync_out (tgl_s)
   );

   function automatic logic [4:0] cfg_index(input logic [7:0] cmd);
      logic [7:0] c;
      c = {cmd[7:1], 1'b0};
      unique case (c)
         sub_pkg::CMD_CHAIN_COUNT: cfg_index = {1'b1, sub_pkg::IDX_CHAIN};
         sub_pkg::CMD_BAUD:        cfg_index = {1'b1, sub_pkg::IDX_BAUD};
         sub_pkg::CMD_ROLE:        cfg_index = {1'b1, sub_pkg::IDX_ROLE};
         sub_pkg::CMD_DEBOUNCE:    cfg_index = {1'b1, sub_pkg::IDX_DBNC};
         sub_pkg::CMD_SAFEMON_A:   cfg_index = {1'b1, sub_pkg::IDX_SMA};
         sub_pkg::CMD_SAFEMON_B:   cfg_index = {1'b1, sub_pkg::IDX_SMB};
         sub_pkg::CMD_SAFEMON_C:   cfg_index = {1'b1, sub_pkg::IDX_SMC};
         sub_pkg::CMD_SAFEMON_D:   cfg_index = {1'b1, sub_pkg::IDX_SMD};
         sub_pkg::CMD_SLEEP:       cfg_index = {1'b1, sub_pkg::IDX_SLP};
         sub_pkg::CMD_COMM:        cfg_index = {1'b1, sub_pkg::IDX_COMM};
         sub_pkg::CMD_PIN_LOW:     cfg_index = {1'b1, sub_pkg::IDX_PLOW};
         sub_pkg::CMD_PIN_HIGH:    cfg_index = {1'b1, sub_pkg::IDX_PHIGH};
         default:                  cfg_index = 5'h00;
      endcase
   endfunction : cfg_index

   // Transaction arrival; cmd stays still until the next frame's command byte, data until its data byte
   wire       xact_done = tgl_s ^ tgl_prev_q;
   wire [4:0] wr_sel    = cfg_index(spi_cmd);
   wire       wr_hit    = xact_done & wr_sel[4] & ~spi_cmd[sub_pkg::CMD_READ_BIT];
   // Read-back crosses unsynchronised: registers only change between frames
   wire [4:0] rd_sel    = cfg_index(spi_cmd);
   assign rd_data = rd_sel[4] ? cfg_q[rd_sel[3:0]] : 8'h00;

   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         tgl_prev_q <= 1'b0;
         for (int i = 0; i < sub_pkg::REG_NUM; i++)
            cfg_q[i] <= sub_pkg::CFG_RESET;
      end
      else
      begin
         tgl_prev_q <= tgl_s;
         if (wr_hit)
            cfg_q[wr_sel[3:0]] <= spi_data;
      end
   end

   // Named fields
   wire [7:0] cfg_dbnc  = cfg_q[sub_pkg::IDX_DBNC];
   wire [7:0] cfg_sma   = cfg_q[sub_pkg::IDX_SMA];
   wire [7:0] cfg_smb   = cfg_q[sub_pkg::IDX_SMB];
   wire [7:0] cfg_smc   = cfg_q[sub_pkg::IDX_SMC];
   wire [7:0] cfg_smd   = cfg_q[sub_pkg::IDX_SMD];
   wire [7:0] cfg_slp   = cfg_q[sub_pkg::IDX_SLP];
   wire [7:0] cfg_plow  = cfg_q[sub_pkg::IDX_PLOW];
   wire [7:0] cfg_phigh = cfg_q[sub_pkg::IDX_PHIGH];
   wire [1:0] role_sel  = cfg_q[sub_pkg::IDX_ROLE][sub_pkg::ROLE_SEL_LSB +: 2];

   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         chain_count_q               <= sub_pkg::CFG_RESET;
         baud_code_q                 <= sub_pkg::CFG_RESET;
         master_single_select_q      <= 2'b00;
         single_uart_master_q        <= 1'b0;
         comm_retry_count_q          <= 4'h0;
         comm_timeout_delay_q        <= 4'h0;
         sleep_alert_packet_enable_q <= 1'b0;
         sleep_balance_notify_q      <= 1'b0;
      end
      else
      begin
         chain_count_q               <= cfg_q[sub_pkg::IDX_CHAIN];
         baud_code_q                 <= cfg_q[sub_pkg::IDX_BAUD];
         master_single_select_q      <= role_sel;
         single_uart_master_q        <= role_sel == sub_pkg::ROLE_MASTER_SINGLE;
         comm_retry_count_q          <= cfg_q[sub_pkg::IDX_COMM][sub_pkg::COMM_RETRY_LSB +: 4];
         comm_timeout_delay_q        <= cfg_q[sub_pkg::IDX_COMM][3:0];
         sleep_alert_packet_enable_q <= cfg_slp[sub_pkg::SLP_ALERT_BIT];
         sleep_balance_notify_q      <= cfg_slp[sub_pkg::SLP_NOTIFY_BIT];
      end
   end

   // Timebase: millisecond, 100 ms and one-second ticks
   logic [15:0] ms_cnt_q;
   logic [6:0]  hms_cnt_q;
   logic [9:0]  sec_cnt_q;
   wire ms_tick  = ms_cnt_q == 16'(MS_CYCLES - 1);
   wire hms_tick = ms_tick && hms_cnt_q == 7'(sub_pkg::RECOVERY_STEP_MS - 1);
   wire sec_tick = ms_tick && sec_cnt_q == 10'(sub_pkg::SEC_MS - 1);

   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         ms_cnt_q  <= 16'h0000;
         hms_cnt_q <= 7'h00;
         sec_cnt_q <= 10'h000;
      end
      else
      begin
         ms_cnt_q <= ms_tick ? 16'h0000 : ms_cnt_q + 16'h0001;
         if (ms_tick)
         begin
            hms_cnt_q <= hms_tick ? 7'h00 : hms_cnt_q + 7'h01;
            sec_cnt_q <= sec_tick ? 10'h000 : sec_cnt_q + 10'h001;
         end
      end
   end

   // Scan periods in seconds; sleep field 3 is the fastest, 1 s
   logic [7:0] safe_sec_q;
   logic [7:0] slp_sec_q;
   wire  [1:0] slp_sel    = cfg_slp[1:0];
   wire  [7:0] slp_period = (slp_sel == 2'b11) ? 8'h01 : (slp_sel == 2'b10) ? 8'h02 : 8'h04;
   wire        safe_due   = safe_monitor_mode && cfg_smc != 8'h00 && sec_tick
                            && safe_sec_q + 8'h01 >= cfg_smc;
   wire        slp_due    = sleep_mode && slp_sel != 2'b00 && sec_tick
                            && slp_sec_q + 8'h01 >= slp_period;

   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         safe_sec_q   <= 8'h00;
         slp_sec_q    <= 8'h00;
         safe_poll_q  <= 1'b0;
         sleep_poll_q <= 1'b0;
      end
      else
      begin
         safe_poll_q  <= safe_due;
         sleep_poll_q <= slp_due;
         if (!safe_monitor_mode || safe_due)
            safe_sec_q <= 8'h00;
         else if (sec_tick)
            safe_sec_q <= safe_sec_q + 8'h01;
         if (!sleep_mode || slp_due)
            slp_sec_q <= 8'h00;
         else if (sec_tick)
            slp_sec_q <= slp_sec_q + 8'h01;
      end
   end

   // Host interrupt on sleep poll results; a new result beats the clear by a transaction
   wire irq_set = poll_result && sleep_mode && cfg_slp[sub_pkg::SLP_IRQ_BIT];

   // Consecutive-error debounce, only in safe-monitor or sleep
   logic [1:0] err_run_q;
   wire        quiet_mode = safe_monitor_mode | sleep_mode;
   wire [1:0]  err_need   = (!quiet_mode || cfg_dbnc[sub_pkg::DBNC_LSB +: 2] == 2'b00)
                            ? 2'b01 : cfg_dbnc[sub_pkg::DBNC_LSB +: 2];
   // Widened sum: a saturated run of 3 must not wrap to 0 and miss the threshold
   wire        err_hit    = chain_error && ({1'b0, err_run_q} + 3'h1 >= {1'b0, err_need});

   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         err_run_q    <= 2'b00;
         error_flag_q <= 1'b0;
         host_irq_q   <= 1'b0;
      end
      else
      begin
         if (chain_error)
            err_run_q <= (err_run_q == 2'b11) ? err_run_q : err_run_q + 2'b01;
         else if (poll_result)
            err_run_q <= 2'b00;
         error_flag_q <= err_hit | (error_flag_q & ~(poll_result & ~chain_error));
         host_irq_q   <= irq_set | (host_irq_q & ~xact_done);
      end
   end

   // Contactor timer: (setting + 4) * 4 minutes of unbroken comm fault
   logic [5:0]  cont_sec_q;
   logic [10:0] cont_min_q;
   wire  [10:0] cont_limit = 11'((11'(cfg_smb) + sub_pkg::CONT_OFFSET) << sub_pkg::CONT_SCALE_LOG2);
   wire         cont_fault = comm_fault & safe_monitor_mode;
   wire         min_tick   = sec_tick && cont_sec_q == 6'(sub_pkg::MIN_SEC - 1);

   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         cont_sec_q       <= 6'h00;
         cont_min_q       <= 11'h000;
         contactor_open_q <= 1'b0;
      end
      else if (!cont_fault)
      begin
         cont_sec_q       <= 6'h00;
         cont_min_q       <= 11'h000;
         contactor_open_q <= 1'b0;
      end
      else
      begin
         if (sec_tick)
            cont_sec_q <= min_tick ? 6'h00 : cont_sec_q + 6'h01;
         if (min_tick && cont_min_q != cont_limit)
            cont_min_q <= cont_min_q + 11'h001;
         contactor_open_q <= cont_min_q == cont_limit;
      end
   end

   // Safe-monitor entry: masked hold, then pins 1,2, then pins 3,4 after the delay
   sub_pkg::sub_seq_t seq_q;
   sub_pkg::sub_seq_t seq_d;
   logic              safe_prev_q;
   logic              entered_q;
   logic [3:0]        rec_cnt_q;
   wire               safe_entry = safe_monitor_mode & ~safe_prev_q;
   wire               rec_done   = rec_cnt_q >= cfg_sma[3:0];

   always_comb
   begin
      seq_d = seq_q;
      unique case (seq_q)
         sub_pkg::SEQ_IDLE:
            if (safe_entry)
               seq_d = (!entered_q && cfg_smd[3:0] != 4'h0) ? sub_pkg::SEQ_MASK
                                                             : sub_pkg::SEQ_LOW;
         sub_pkg::SEQ_MASK:
            if (safe_due)
               seq_d = sub_pkg::SEQ_LOW;
         sub_pkg::SEQ_LOW:
            if (rec_done)
               seq_d = sub_pkg::SEQ_ALL;
         sub_pkg::SEQ_ALL:
            seq_d = sub_pkg::SEQ_ALL;
      endcase
      if (!safe_monitor_mode)
         seq_d = sub_pkg::SEQ_IDLE;
   end

   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         seq_q       <= sub_pkg::SEQ_IDLE;
         safe_prev_q <= 1'b0;
         entered_q   <= 1'b0;
         rec_cnt_q   <= 4'h0;
      end
      else
      begin
         seq_q       <= seq_d;
         safe_prev_q <= safe_monitor_mode;
         entered_q   <= entered_q | safe_entry;
         if (seq_q != sub_pkg::SEQ_LOW)
            rec_cnt_q <= 4'h0;
         else if (hms_tick && !rec_done)
            rec_cnt_q <= rec_cnt_q + 4'h1;
      end
   end

   // Pin roles
   wire pin1_contactor = cfg_plow[3:0] == sub_pkg::FN_CONTACTOR_NMOS;
   wire pin2_contactor = cfg_plow[7:4] == sub_pkg::FN_CONTACTOR_NMOS;
   wire pin3_handover  = cfg_phigh[3:0] == sub_pkg::FN_HANDOVER;
   wire pin4_reset     = cfg_phigh[7:4] == sub_pkg::FN_MCU_RESET;
   wire low_on         = seq_q == sub_pkg::SEQ_LOW || seq_q == sub_pkg::SEQ_ALL;
   wire high_on        = seq_q == sub_pkg::SEQ_ALL;
   wire drive_close    = safe_monitor_mode & ~contactor_open_q & low_on;
   wire handover_d     = pin3_handover & high_on & safe_monitor_mode;
   wire reset_d        = pin4_reset & cont_fault;
   wire [3:0] mask_now = (seq_q == sub_pkg::SEQ_MASK) ? cfg_smd[3:0] : 4'h0;
   wire [3:0] pins_d   = {reset_d & high_on, handover_d,
                          pin2_contactor & drive_close, pin1_contactor & drive_close};

   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         gpio_out_q      <= 4'h0;
         comm_handover_q <= 1'b0;
         mcu_reset_q     <= 1'b0;
      end
      else
      begin
         gpio_out_q      <= pins_d & ~mask_now;
         comm_handover_q <= handover_d;
         mcu_reset_q     <= reset_d;
      end
   end

   sequence s_entry_masked;
      safe_entry && !entered_q && cfg_smd[3:0] != 4'h0;
   endsequence

   a_write_stores: assert property (@(posedge clock) disable iff (sys_rst)
      wr_hit |=> cfg_q[$past(wr_sel[3:0])] == $past(spi_data))
      else $error("configuration write not stored");
   a_read_back_value: assert property (@(posedge clock) disable iff (sys_rst)
      rd_sel[4] && !wr_hit |=> rd_data == $past(rd_data) || $changed(spi_cmd))
      else $error("read-back value drifted without a write");
   a_role_master_flag: assert property (@(posedge clock) disable iff (sys_rst)
      $past(role_sel) == 2'b10 |-> single_uart_master_q)
      else $error("master single-UART not flagged");
   a_error_single_hit: assert property (@(posedge clock) disable iff (sys_rst)
      chain_error && quiet_mode && err_run_q == 2'b00 && cfg_dbnc[3:2] == 2'b10
      && !error_flag_q |=> !error_flag_q)
      else $error("error flagged before two consecutive errors");
   a_mask_holds_pins: assert property (@(posedge clock) disable iff (sys_rst)
      s_entry_masked ##1 seq_q == sub_pkg::SEQ_MASK |=> (gpio_out_q & cfg_smd[3:0]) == 4'h0)
      else $error("masked pin driven on first safe entry");
   a_pins_high_after: assert property (@(posedge clock) disable iff (sys_rst)
      gpio_out_q[2] |-> $past(seq_q) == sub_pkg::SEQ_ALL)
      else $error("pin 3 driven before recovery delay");
   a_contactor_timer: assert property (@(posedge clock) disable iff (sys_rst)
      $rose(contactor_open_q) |-> $past(cont_min_q) == $past(cont_limit) && $past(cont_fault))
      else $error("contactor opened before timer expiry");
   a_safe_poll_off: assert property (@(posedge clock) disable iff (sys_rst)
      safe_poll_q |-> $past(safe_monitor_mode) && $past(sec_tick))
      else $error("safe poll outside one-second tick");
   a_contactor_pins: assert property (@(posedge clock) disable iff (sys_rst)
      gpio_out_q[0] |-> $past(safe_monitor_mode) && $past(pin1_contactor))
      else $error("pin 1 contactor drive outside safe mode");
   a_sleep_irq_set: assert property (@(posedge clock) disable iff (sys_rst)
      irq_set |=> host_irq_q)
      else $error("sleep result did not raise interrupt");
endmodule : sub_bridge_config

// [core/sub_pkg.sv]
// Shared constants for the single-UART bridge configuration block
// Summary of operation
// - Command 60h with a count sets the daisy-chain device count used as chain length.
// - Command 62h with data 30h selects a 2 Mbps UART baud rate.
// - Command 68h with 28h selects master single-UART, select field equal to 0b10.
// - Debounce 08h on command 6Ah flags errors after two consecutive errors in safe/sleep.
// - Recovery delay 5Ah on command 6Ch spaces pins 1,2 and pins 3,4 by one second.
// - Contactor timer FEh on command 6Eh opens contactor 1032 minutes after comm fault.
// - Safe-monitor scan delay 01h on command 70h polls the chain every second.
// - Mask 0Fh on command 72h holds pins 1-4 off on first safe-monitor entry.
// - Sleep config 1Fh on command 74h polls each second in sleep, interrupt to host.
// - Pin pair config 66h on command 80h makes pins 1,2 contactor drivers in safe mode.
// - Pin pair config 46h on command 82h gives handover on pin 3, reset on pin 4.
// - Reading a configuration register returns the stored value unchanged.
package sub_pkg;
   // Command bytes; bit 0 set turns a write command into a read of the same register
   localparam logic [7:0] CMD_CHAIN_COUNT  = 8'h60;
   localparam logic [7:0] CMD_BAUD         = 8'h62;
   localparam logic [7:0] CMD_ROLE         = 8'h68;
   localparam logic [7:0] CMD_DEBOUNCE     = 8'h6a;
   localparam logic [7:0] CMD_SAFEMON_A    = 8'h6c;
   localparam logic [7:0] CMD_SAFEMON_B    = 8'h6e;
   localparam logic [7:0] CMD_SAFEMON_C    = 8'h70;
   localparam logic [7:0] CMD_SAFEMON_D    = 8'h72;
   localparam logic [7:0] CMD_SLEEP        = 8'h74;
   localparam logic [7:0] CMD_COMM         = 8'h76;
   localparam logic [7:0] CMD_PIN_LOW      = 8'h80;
   localparam logic [7:0] CMD_PIN_HIGH     = 8'h82;
   localparam int         CMD_READ_BIT     = 0;

   // Register array indices
   localparam int REG_NUM = 12;
   localparam logic [3:0] IDX_CHAIN = 4'h0;
   localparam logic [3:0] IDX_BAUD  = 4'h1;
   localparam logic [3:0] IDX_ROLE  = 4'h2;
   localparam logic [3:0] IDX_DBNC  = 4'h3;
   localparam logic [3:0] IDX_SMA   = 4'h4;
   localparam logic [3:0] IDX_SMB   = 4'h5;
   localparam logic [3:0] IDX_SMC   = 4'h6;
   localparam logic [3:0] IDX_SMD   = 4'h7;
   localparam logic [3:0] IDX_SLP   = 4'h8;
   localparam logic [3:0] IDX_COMM  = 4'h9;
   localparam logic [3:0] IDX_PLOW  = 4'ha;
   localparam logic [3:0] IDX_PHIGH = 4'hb;
   localparam logic [7:0] CFG_RESET = 8'h00;

   // Field positions
   localparam int ROLE_SEL_LSB   = 4;
   localparam int DBNC_LSB       = 2;
   localparam int SLP_ALERT_BIT  = 2;
   localparam int SLP_NOTIFY_BIT = 3;
   localparam int SLP_IRQ_BIT    = 4;
   localparam int COMM_RETRY_LSB = 4;
   localparam logic [1:0] ROLE_MASTER_SINGLE = 2'b10;

   // Pin function codes, one nibble per pin
   localparam logic [3:0] FN_CONTACTOR_NMOS = 4'h6;
   localparam logic [3:0] FN_HANDOVER       = 4'h6;
   localparam logic [3:0] FN_MCU_RESET      = 4'h4;

   // Timebase
   localparam int CLK_MHZ        = 50;
   localparam int MS_US          = 1000;
   localparam int MS_CYCLES      = CLK_MHZ * MS_US;
   localparam int RECOVERY_STEP_MS = 100;
   localparam int SEC_MS         = 1000;
   localparam int MIN_SEC        = 60;
   localparam logic [10:0] CONT_OFFSET = 11'h004;
   localparam int CONT_SCALE_LOG2 = 2;

   typedef enum logic [1:0]
   {
      SEQ_IDLE = 2'b00,
      SEQ_MASK = 2'b01,
      SEQ_LOW  = 2'b10,
      SEQ_ALL  = 2'b11
   } sub_seq_t;
endpackage : sub_pkg

// [core/sub_sync.sv]
// Two-flop level synchroniser
`timescale 1ns/1ps
module sub_sync #(parameter int W = 1)
(
   // Destination clock
   input  wire logic         clock,
   input  wire logic         sys_rst,
   // Level in and out
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);
   logic [W-1:0] meta_q;

   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         meta_q   <= '0;
         sync_out <= '0;
      end
      else
      begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule : sub_sync

// [core/sub_spi_link.sv]
// SPI slave, mode 0, running on the host's serial clock
`timescale 1ns/1ps
module sub_spi_link
(
   // Link pins
   input  wire logic       spi_sclk,
   input  wire logic       spi_cs_n,
   input  wire logic       spi_mosi,
   output logic            spi_miso,
   output logic            spi_miso_oe,
   input  wire logic       sys_rst,
   // Transaction out, read data in
   input  wire logic [7:0] rd_data,
   output logic      [7:0] cmd_q,
   output logic      [7:0] data_q,
   output logic            done_tgl_q
);
   logic [6:0] sh_q;
   logic [4:0] cnt_q;
   logic [6:0] out_q;
   wire        frame_rst = sys_rst | spi_cs_n;
   wire  [7:0] byte_in   = {sh_q, spi_mosi};

   // Counter restarts with every select; clock stands still between frames
   always_ff @(posedge spi_sclk or posedge frame_rst)
   begin
      if (frame_rst)
      begin
         sh_q  <= 7'h00;
         cnt_q <= 5'h00;
      end
      else
      begin
         sh_q  <= byte_in[6:0];
         cnt_q <= (cnt_q == 5'h10) ? cnt_q : cnt_q + 5'h01;
      end
   end

   // Command then data byte form one transaction
   always_ff @(posedge spi_sclk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         cmd_q      <= 8'h00;
         data_q     <= 8'h00;
         done_tgl_q <= 1'b0;
      end
      else if (!spi_cs_n && cnt_q == 5'h07)
         cmd_q <= byte_in;
      else if (!spi_cs_n && cnt_q == 5'h0f)
      begin
         data_q     <= byte_in;
         done_tgl_q <= ~done_tgl_q;
      end
   end

   // Read data leaves on falling edges after the command byte
   always_ff @(negedge spi_sclk or posedge frame_rst)
   begin
      if (frame_rst)
      begin
         spi_miso    <= 1'b0;
         spi_miso_oe <= 1'b0;
         out_q       <= 7'h00;
      end
      else
      begin
         spi_miso_oe <= 1'b1;
         if (cnt_q == 5'h08)
         begin
            spi_miso <= rd_data[7];
            out_q    <= rd_data[6:0];
         end
         else
         begin
            spi_miso <= out_q[6];
            out_q    <= {out_q[5:0], 1'b0};
         end
      end
   end
endmodule : sub_spi_link

// [dv/sub_spi_host.sv]
// Host-side SPI master model, mode 0, 125 ns serial clock
`timescale 1ns/1ps
module sub_spi_host
(
   // Link pins
   output logic      spi_sclk,
   output logic      spi_cs_n,
   output logic      spi_mosi,
   input  wire logic spi_miso
);
   initial
   begin
      spi_sclk = 1'b0;
      spi_cs_n = 1'b1;
      spi_mosi = 1'b0;
   end

   // One whole frame: command byte then data byte, MSB first
   task automatic xfer(input logic [15:0] word, output logic [7:0] rd);
      spi_cs_n = 1'b0;
      for (int i = 15; i >= 0; i--)
      begin
         spi_mosi = word[i];
         #62.5 spi_sclk = 1'b1;
         if (i < 8)
            rd[i] = spi_miso;
         #62.5 spi_sclk = 1'b0;
      end
      // Released data line must not keep showing the last bit
      spi_mosi = ~spi_mosi;
      // Gap covers the device's sync and write latency
      #200 spi_cs_n = 1'b1;
      #300;
   endtask : xfer
endmodule : sub_spi_host

// [dv/sub_bridge_config_tb_top.sv]
// Self-checking bench for the bridge configuration block
`timescale 1ns/1ps
module sub_bridge_config_tb_top;
   logic clock, sys_rst, spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe;
   logic safe_monitor_mode, sleep_mode, chain_error, poll_result, comm_fault;
   logic [7:0] chain_count_q, baud_code_q;
   logic [1:0] master_single_select_q;
   logic [3:0] comm_retry_count_q, comm_timeout_delay_q, gpio_out_q;
   logic single_uart_master_q, sleep_alert_packet_enable_q, sleep_balance_notify_q;
   logic error_flag_q, safe_poll_q, sleep_poll_q, host_irq_q;
   logic contactor_open_q, mcu_reset_q, comm_handover_q;
   int   error_cnt = 0;
   int   num_checks = 0;

   sub_bridge_config #(.MS_CYCLES(5)) sub_bridge_config_i (.clock, .sys_rst, .spi_sclk,
      .spi_cs_n, .spi_mosi, .spi_miso, .spi_miso_oe, .safe_monitor_mode, .sleep_mode,
      .chain_error, .poll_result, .comm_fault, .chain_count_q, .baud_code_q,
      .master_single_select_q, .single_uart_master_q, .comm_retry_count_q,
      .comm_timeout_delay_q, .sleep_alert_packet_enable_q, .sleep_balance_notify_q,
      .error_flag_q, .safe_poll_q, .sleep_poll_q, .host_irq_q, .contactor_open_q,
      .mcu_reset_q, .comm_handover_q, .gpio_out_q);
   sub_spi_host sub_spi_host_i (.spi_sclk, .spi_cs_n, .spi_mosi, .spi_miso);

   initial
   begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic close_out;
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : close_out

   // Bounded wait on a design output, sampled at clock edges
   task automatic wait_hi(ref logic s, input int lim);
      int n;
      n = 0;
      while (s !== 1'b1 && n < lim)
      begin
         @(posedge clock);
         n++;
      end
      if (n >= lim)
      begin
         error_cnt++;
         $display("CHECK FAILED %0t wait ran out", $time);
         close_out();
      end
   endtask : wait_hi

   task automatic t_regs;
      logic [15:0] tbl [12];
      logic [7:0]  rd;
      tbl = '{16'h6007, 16'h6230, 16'h6828, 16'h6a08, 16'h6c5a, 16'h6efe,
              16'h7001, 16'h720f, 16'h741f, 16'h7602, 16'h8066, 16'h8246};
      check(spi_miso_oe, 1'b0);
      foreach (tbl[i])
      begin
         sub_spi_host_i.xfer(tbl[i], rd);
         sub_spi_host_i.xfer({tbl[i][15:8] | 8'h01, 8'h00}, rd);
         check(rd, tbl[i][7:0]);
      end
      sub_spi_host_i.xfer(16'h1100, rd);
      check(rd, 8'h00);
      check(chain_count_q, 8'h07);
      check(baud_code_q, 8'h30);
      check(master_single_select_q, 2'b10);
      check(single_uart_master_q, 1'b1);
      check(comm_timeout_delay_q, 4'h2);
      check(comm_retry_count_q, 4'h0);
      check({sleep_balance_notify_q, sleep_alert_packet_enable_q}, 2'b11);
   endtask : t_regs

   task automatic t_safe;
      @(posedge clock) safe_monitor_mode <= 1'b1;
      @(posedge clock) chain_error <= 1'b1;
      @(posedge clock) chain_error <= 1'b0;
      repeat (3) @(posedge clock);
      check(error_flag_q, 1'b0);
      check(gpio_out_q, 4'h0);
      chain_error <= 1'b1;
      @(posedge clock) chain_error <= 1'b0;
      repeat (2) @(posedge clock);
      check(error_flag_q, 1'b1);
      wait_hi(safe_poll_q, 5200);
      repeat (3) @(posedge clock);
      check(gpio_out_q[1:0], 2'b11);
      check(gpio_out_q[3:2], 2'b00);
      // Recovery delay is ten 100 ms steps; well short of it pin 3 must still be off
      repeat (4000) @(posedge clock);
      check(gpio_out_q[2], 1'b0);
      wait_hi(comm_handover_q, 1200);
      check(gpio_out_q[2], 1'b1);
      comm_fault <= 1'b1;
      wait_hi(mcu_reset_q, 20);
      check(gpio_out_q[3], 1'b1);
      check(contactor_open_q, 1'b0);
      comm_fault <= 1'b0;
   endtask : t_safe

   task automatic t_sleep;
      logic [7:0] rd;
      @(posedge clock) safe_monitor_mode <= 1'b0;
      sleep_mode <= 1'b1;
      @(posedge clock) poll_result <= 1'b1;
      @(posedge clock) poll_result <= 1'b0;
      @(posedge clock);
      check(host_irq_q, 1'b1);
      check(gpio_out_q, 4'h0);
      sub_spi_host_i.xfer(16'h6100, rd);
      check(rd, 8'h07);
      check(host_irq_q, 1'b0);
      wait_hi(sleep_poll_q, 5200);
   endtask : t_sleep

   initial
   begin
      sys_rst = 1'b1;
      {safe_monitor_mode, sleep_mode, chain_error, poll_result, comm_fault} = 5'h00;
      repeat (5) @(posedge clock);
      sys_rst <= 1'b0;
      repeat (3) @(posedge clock);
      t_regs();
      t_safe();
      t_sleep();
      close_out();
   end
endmodule : sub_bridge_config_tb_top
